// ### design/ccu_top.sv
// Comparator control unit: APB register file, source and ladder control, result routing,
// interrupt and ADC trigger generation around one analog comparator.
// Assumes the analog core returns its result asynchronously and that clk_gate_en_i comes
// from the system clock-gating logic on ref_clk_i.
//
// Operation
// - Source code 00/01 routes positive pin, 10 internal reference, 11 reserved.
// - Negative comparator input always connects to its dedicated pin.
// - Result drives output pin, interrupt source and ADC trigger.
// - Interrupt and ADC trigger have separate edge/level detection.
// - Ladder disabled gives ground reference regardless of tap.
// - Enabled, range 0: reference is (tap plus 8) over 32.
// - Enabled, range 1: reference is tap over 24.
// - Reference word 0x30C enables ladder, range 1, tap 12.
// - Control word 0x40C selects internal reference, output not inverted.
// - Software reads the result from the status register value bit.
// - Masked status W1C, raw status read-only, enable read/write, all reset zero.
// - Registers decode at offsets 0x00, 0x04, 0x08, 0x10, 0x20, 0x24.
// - Masked status bit 0 shows masked interrupt; writing 1 clears it.
//
// The APB interface to the registers was left to the implementer.
`include "ccu_defs.svh"

module ccu_top (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_gate_en_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic compare_result_i,
    output logic pos_src_pin_o,
    output logic pos_src_internal_o,
    output logic neg_src_pin_o,
    output logic ladder_enable_o,
    output logic ladder_range_bit_o,
    output logic [4:0] ladder_numerator_o,
    output logic result_output_pin_o,
    output logic irq_o,
    output logic adc_trigger_o
);

    // ======================================================================
    // Register storage
    // ======================================================================
    logic compare_irq_bit;
    logic irq_enable;
    logic ref_enable;
    logic ladder_range_bit;
    logic [3:0] ref_tap;
    logic output_invert;
    ccu_pkg::ccu_sense_t irq_sense;
    logic irq_level;
    ccu_pkg::ccu_sense_t trg_sense;
    logic trg_level;
    ccu_pkg::ccu_source_t positive_source_select;
    logic trg_enable;

    // ======================================================================
    // Result synchronisation and edge history
    // ======================================================================
    logic result_sync;
    logic result_prev;
    logic irq_hit;
    logic trg_hit;

    // The analog result is asynchronous, so nothing reads it before two flops.
    ccu_sync u_result_sync (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .async_i(compare_result_i),
        .sync_o(result_sync)
    );

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            result_prev <= 1'b0;
        end else begin
            result_prev <= result_sync;
        end
    end

    ccu_sense u_irq_sense (
        .cur_i(result_sync),
        .prev_i(result_prev),
        .mode_i(irq_sense),
        .level_i(irq_level),
        .hit_o(irq_hit)
    );

    ccu_sense u_trg_sense (
        .cur_i(result_sync),
        .prev_i(result_prev),
        .mode_i(trg_sense),
        .level_i(trg_level),
        .hit_o(trg_hit)
    );

    // ======================================================================
    // APB decode
    // ======================================================================
    logic bus_access;
    logic bus_write;
    logic bus_read;
    logic sel_mis;
    logic sel_ris;
    logic sel_inten;
    logic sel_ref;
    logic sel_stat;
    logic sel_ctl;
    logic addr_hit;
    logic wr_mis;
    logic wr_inten;
    logic wr_ref;
    logic wr_ctl;
    logic masked_irq;
    logic [31:0] next_prdata;

    // Access phase with the clock gate open; a gated-off block answers with an error.
    assign bus_access = psel & penable & clk_gate_en_i;
    assign bus_write = bus_access & pwrite;
    assign bus_read = bus_access & ~pwrite;

    assign sel_mis = (paddr == `CCU_OFS_MASKED_IRQ_STATUS);
    assign sel_ris = (paddr == `CCU_OFS_RAW_IRQ_STATUS);
    assign sel_inten = (paddr == `CCU_OFS_IRQ_ENABLE);
    assign sel_ref = (paddr == `CCU_OFS_REFERENCE_CONTROL);
    assign sel_stat = (paddr == `CCU_OFS_COMPARE_STATUS);
    assign sel_ctl = (paddr == `CCU_OFS_COMPARE_CONTROL);
    assign addr_hit = sel_mis | sel_ris | sel_inten | sel_ref | sel_stat | sel_ctl;

    assign wr_mis = bus_write & sel_mis;
    assign wr_inten = bus_write & sel_inten;
    assign wr_ref = bus_write & sel_ref;
    assign wr_ctl = bus_write & sel_ctl;

    // Zero wait states: every access completes in its first access cycle.
    assign pready = 1'b1;
    assign pslverr = psel & penable & (~addr_hit | ~clk_gate_en_i);

    // ======================================================================
    // Interrupt status
    // ======================================================================
    // masked bit forms the request
    assign masked_irq = compare_irq_bit & irq_enable;
    assign irq_o = masked_irq;

    // Level sense resets to level zero, so a low result sets the raw bit right after reset.
    // Software programs the sense mode and clears the bit before it enables the interrupt.
    // raw status sticky, set wins over clear
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            compare_irq_bit <= 1'b0;
        end else if (irq_hit) begin
            compare_irq_bit <= 1'b1;
        end else if (wr_mis && pwdata[`CCU_IRQ_BIT]) begin
            compare_irq_bit <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_enable <= 1'b0;
        end else if (wr_inten) begin
            irq_enable <= pwdata[`CCU_IRQ_BIT];
        end
    end

    // ======================================================================
    // Reference and control registers
    // ======================================================================
    // Write data split into named fields; the field layout lives in the defs header.
    logic field_ref_enable;
    logic field_ref_range;
    logic [3:0] field_ref_tap;
    logic field_invert;
    ccu_pkg::ccu_sense_t field_irq_sense;
    logic field_irq_level;
    ccu_pkg::ccu_sense_t field_trg_sense;
    logic field_trg_level;
    ccu_pkg::ccu_source_t field_source;
    logic field_trg_enable;

    assign field_ref_enable = pwdata[`CCU_REF_ENABLE_BIT];
    assign field_ref_range = pwdata[`CCU_REF_RANGE_BIT];
    assign field_ref_tap = pwdata[`CCU_REF_TAP_MSB:`CCU_REF_TAP_LSB];
    assign field_invert = pwdata[`CCU_CTL_INVERT_BIT];
    assign field_irq_sense = ccu_pkg::ccu_sense_t'(pwdata[`CCU_CTL_IRQ_SENSE_MSB:`CCU_CTL_IRQ_SENSE_LSB]);
    assign field_irq_level = pwdata[`CCU_CTL_IRQ_LEVEL_BIT];
    assign field_trg_sense = ccu_pkg::ccu_sense_t'(pwdata[`CCU_CTL_TRG_SENSE_MSB:`CCU_CTL_TRG_SENSE_LSB]);
    assign field_trg_level = pwdata[`CCU_CTL_TRG_LEVEL_BIT];
    assign field_source = ccu_pkg::ccu_source_t'(pwdata[`CCU_CTL_SRC_MSB:`CCU_CTL_SRC_LSB]);
    assign field_trg_enable = pwdata[`CCU_CTL_TRG_ENABLE_BIT];

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ref_enable <= 1'b0;
            ladder_range_bit <= 1'b0;
            ref_tap <= 4'h0;
        end else if (wr_ref) begin
            ref_enable <= field_ref_enable;
            ladder_range_bit <= field_ref_range;
            ref_tap <= field_ref_tap;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            output_invert <= 1'b0;
            irq_sense <= ccu_pkg::CCU_SENSE_LEVEL;
            irq_level <= 1'b0;
            trg_sense <= ccu_pkg::CCU_SENSE_LEVEL;
            trg_level <= 1'b0;
            positive_source_select <= ccu_pkg::CCU_SRC_PIN_A;
            trg_enable <= 1'b0;
        end else if (wr_ctl) begin
            output_invert <= field_invert;
            irq_sense <= field_irq_sense;
            irq_level <= field_irq_level;
            trg_sense <= field_trg_sense;
            trg_level <= field_trg_level;
            positive_source_select <= field_source;
            trg_enable <= field_trg_enable;
        end
    end

    // ======================================================================
    // Read data
    // ======================================================================
    logic [31:0] rd_ref;
    logic [31:0] rd_ctl;

    always_comb begin
        rd_ref = `CCU_RST_REG;
        rd_ref[`CCU_REF_ENABLE_BIT] = ref_enable;
        rd_ref[`CCU_REF_RANGE_BIT] = ladder_range_bit;
        rd_ref[`CCU_REF_TAP_MSB:`CCU_REF_TAP_LSB] = ref_tap;
    end

    always_comb begin
        rd_ctl = `CCU_RST_REG;
        rd_ctl[`CCU_CTL_INVERT_BIT] = output_invert;
        rd_ctl[`CCU_CTL_IRQ_SENSE_MSB:`CCU_CTL_IRQ_SENSE_LSB] = irq_sense;
        rd_ctl[`CCU_CTL_IRQ_LEVEL_BIT] = irq_level;
        rd_ctl[`CCU_CTL_TRG_SENSE_MSB:`CCU_CTL_TRG_SENSE_LSB] = trg_sense;
        rd_ctl[`CCU_CTL_TRG_LEVEL_BIT] = trg_level;
        rd_ctl[`CCU_CTL_SRC_MSB:`CCU_CTL_SRC_LSB] = positive_source_select;
        rd_ctl[`CCU_CTL_TRG_ENABLE_BIT] = trg_enable;
    end

    always_comb begin
        next_prdata = `CCU_RST_REG;
        if (sel_mis) begin
            next_prdata[`CCU_IRQ_BIT] = masked_irq;
        end else if (sel_ris) begin
            next_prdata[`CCU_IRQ_BIT] = compare_irq_bit;
        end else if (sel_inten) begin
            next_prdata[`CCU_IRQ_BIT] = irq_enable;
        end else if (sel_ref) begin
            next_prdata = rd_ref;
        end else if (sel_stat) begin
            next_prdata[`CCU_STAT_VALUE_BIT] = result_sync;
        end else if (sel_ctl) begin
            next_prdata = rd_ctl;
        end
    end

    // Read data is registered in the setup cycle so it stands stable through the access.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata <= `CCU_RST_REG;
        end else if (psel && !penable && !pwrite && clk_gate_en_i) begin
            prdata <= next_prdata;
        end else if (bus_read) begin
            prdata <= prdata;
        end else begin
            prdata <= `CCU_RST_REG;
        end
    end

    // ======================================================================
    // Analog side controls
    // ======================================================================
    logic next_pos_pin;
    logic next_pos_internal;
    logic [4:0] next_numerator;

    // positive source routing; reserved code connects nothing
    assign next_pos_pin = (positive_source_select == ccu_pkg::CCU_SRC_PIN_A) |
                          (positive_source_select == ccu_pkg::CCU_SRC_PIN_B);
    assign next_pos_internal = (positive_source_select == ccu_pkg::CCU_SRC_INTERNAL);

    assign next_numerator = !ref_enable ? 5'h00 :
                            ladder_range_bit ? {1'b0, ref_tap} :
                            ({1'b0, ref_tap} + `CCU_LADDER_LOW_OFFSET);

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pos_src_pin_o <= 1'b0;
            pos_src_internal_o <= 1'b0;
            neg_src_pin_o <= 1'b0;
            ladder_enable_o <= 1'b0;
            ladder_range_bit_o <= 1'b0;
            ladder_numerator_o <= 5'h00;
        end else begin
            pos_src_pin_o <= next_pos_pin;
            pos_src_internal_o <= next_pos_internal;
            neg_src_pin_o <= 1'b1;
            ladder_enable_o <= ref_enable;
            ladder_range_bit_o <= ladder_range_bit;
            ladder_numerator_o <= next_numerator;
        end
    end

    // ======================================================================
    // Result routing
    // ======================================================================
    // pin and ADC trigger outputs
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            result_output_pin_o <= 1'b0;
            adc_trigger_o <= 1'b0;
        end else begin
            result_output_pin_o <= result_sync ^ output_invert;
            adc_trigger_o <= trg_hit & trg_enable;
        end
    end

endmodule : ccu_top

// ### design/ccu_defs.svh
// Register offsets, field positions, reset values and ladder figures of the comparator control unit.
// Assumes inclusion by bare name from the package and from the design modules.
`ifndef CCU_DEFS_SVH
`define CCU_DEFS_SVH

// ==========================================================================
// Register offsets (byte addresses within the block)
// ==========================================================================
`define CCU_BASE_ADDR 32'h4003_C000
`define CCU_OFS_MASKED_IRQ_STATUS 12'h000
`define CCU_OFS_RAW_IRQ_STATUS 12'h004
`define CCU_OFS_IRQ_ENABLE 12'h008
`define CCU_OFS_REFERENCE_CONTROL 12'h010
`define CCU_OFS_COMPARE_STATUS 12'h020
`define CCU_OFS_COMPARE_CONTROL 12'h024

// ==========================================================================
// Reset values
// ==========================================================================
`define CCU_RST_REG 32'h0000_0000

// ==========================================================================
// Field positions
// ==========================================================================
`define CCU_IRQ_BIT 0
`define CCU_REF_TAP_LSB 0
`define CCU_REF_TAP_MSB 3
`define CCU_REF_RANGE_BIT 8
`define CCU_REF_ENABLE_BIT 9
`define CCU_CTL_INVERT_BIT 1
`define CCU_CTL_IRQ_SENSE_LSB 2
`define CCU_CTL_IRQ_SENSE_MSB 3
`define CCU_CTL_IRQ_LEVEL_BIT 4
`define CCU_CTL_TRG_SENSE_LSB 5
`define CCU_CTL_TRG_SENSE_MSB 6
`define CCU_CTL_TRG_LEVEL_BIT 7
`define CCU_CTL_SRC_LSB 9
`define CCU_CTL_SRC_MSB 10
`define CCU_CTL_TRG_ENABLE_BIT 11
`define CCU_STAT_VALUE_BIT 1

// ==========================================================================
// Ladder figures
// ==========================================================================
`define CCU_LADDER_LOW_OFFSET 5'h08

`endif

// ### design/ccu_pkg.sv
// Types shared by the comparator control unit modules.
// Assumes ccu_defs.svh sits on the include path.
`include "ccu_defs.svh"

package ccu_pkg;

    // ======================================================================
    // Event sense modes
    // ======================================================================
    typedef enum logic [1:0] {
        CCU_SENSE_LEVEL = 2'h0,
        CCU_SENSE_FALL = 2'h1,
        CCU_SENSE_RISE = 2'h2,
        CCU_SENSE_BOTH = 2'h3
    } ccu_sense_t;

    // ======================================================================
    // Positive input source codes
    // ======================================================================
    typedef enum logic [1:0] {
        CCU_SRC_PIN_A = 2'h0,
        CCU_SRC_PIN_B = 2'h1,
        CCU_SRC_INTERNAL = 2'h2,
        CCU_SRC_RESERVED = 2'h3
    } ccu_source_t;

endpackage : ccu_pkg

// ### design/ccu_sync.sv
// Two-stage synchroniser for one level coming from outside the clock domain.
// Assumes the input may change at any time relative to ref_clk_i.
module ccu_sync (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic async_i,
    output logic sync_o
);

    logic stage_one;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stage_one <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            stage_one <= async_i;
            sync_o <= stage_one;
        end
    end

endmodule : ccu_sync

// ### design/ccu_sense.sv
// Edge or level detector for one path of the comparison result.
// Assumes cur_i and prev_i are already synchronised and one cycle apart.
module ccu_sense (
    input wire logic cur_i,
    input wire logic prev_i,
    input wire ccu_pkg::ccu_sense_t mode_i,
    input wire logic level_i,
    output logic hit_o
);

    logic rise;
    logic fall;

    assign rise = cur_i & ~prev_i;
    assign fall = ~cur_i & prev_i;

    always_comb begin
        case (mode_i)
            ccu_pkg::CCU_SENSE_LEVEL: hit_o = (cur_i == level_i);
            ccu_pkg::CCU_SENSE_FALL: hit_o = fall;
            ccu_pkg::CCU_SENSE_RISE: hit_o = rise;
            default: hit_o = rise | fall;
        endcase
    end

endmodule : ccu_sense

// ### tb/ccu_top_monitor.sv
// Port checker for ccu_top, attached by the bind at the foot of this file.
// Assumes one clock domain and zero-wait APB answers.
module ccu_top_monitor (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_gate_en_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic compare_result_i,
    input wire logic pos_src_pin_o,
    input wire logic pos_src_internal_o,
    input wire logic neg_src_pin_o,
    input wire logic ladder_enable_o,
    input wire logic ladder_range_bit_o,
    input wire logic [4:0] ladder_numerator_o,
    input wire logic irq_o,
    input wire logic adc_trigger_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic mapped;
    logic rd_setup;
    assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h010, 12'h020, 12'h024};
    assign rd_setup = psel && !penable && !pwrite && clk_gate_en_i;
    // ======================================================================
    // Assertions
    // ======================================================================
    chk_src_exclusive: assert property (!(pos_src_pin_o && pos_src_internal_o))
        else $error("both positive sources selected");
    chk_neg_fixed: assert property ($past(rst_b_i) |-> neg_src_pin_o)
        else $error("negative pin not connected");
    chk_ladder_off: assert property (!ladder_enable_o |-> ladder_numerator_o == 5'h00)
        else $error("disabled ladder not at ground");
    chk_ladder_low: assert property (ladder_enable_o && !ladder_range_bit_o
        |-> ladder_numerator_o inside {[8:23]}) else $error("low range tap out of span");
    chk_ladder_high: assert property (ladder_enable_o && ladder_range_bit_o
        |-> ladder_numerator_o <= 5'h0f) else $error("high range tap out of span");
    chk_mis_read: assert property (rd_setup && paddr == 12'h000
        |=> prdata[0] == $past(irq_o)) else $error("masked status differs from irq");
    chk_status_read: assert property ($stable(compare_result_i) [*5]
        ##0 (rd_setup && paddr == 12'h020) |=> prdata[1] == $past(compare_result_i))
        else $error("status value differs from result");
    chk_idle_rdata: assert property (!psel && !$past(psel) |-> prdata == 32'h0000_0000)
        else $error("read data not zero when idle");
    chk_unmapped_err: assert property (psel && penable && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    chk_gate_err: assert property (psel && penable && !clk_gate_en_i |-> pslverr)
        else $error("gated access not refused");
    cov_irq: cover property ($rose(irq_o));
    cov_trig: cover property ($rose(adc_trigger_o));
    cov_gate: cover property (psel && penable && !clk_gate_en_i);
endmodule : ccu_top_monitor

bind ccu_top ccu_top_monitor u_mon (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .clk_gate_en_i(clk_gate_en_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .compare_result_i(compare_result_i),
    .pos_src_pin_o(pos_src_pin_o), .pos_src_internal_o(pos_src_internal_o),
    .neg_src_pin_o(neg_src_pin_o), .ladder_enable_o(ladder_enable_o),
    .ladder_range_bit_o(ladder_range_bit_o), .ladder_numerator_o(ladder_numerator_o),
    .irq_o(irq_o), .adc_trigger_o(adc_trigger_o));

// ### tb/ccu_analog_model.sv
// Behavioural analog comparator core with its reference ladder.
// Assumes the bench gives pin levels in 96ths of the analog supply.
module ccu_analog_model (
    input wire logic pos_src_pin_i,
    input wire logic pos_src_internal_i,
    input wire logic neg_src_pin_i,
    input wire logic ladder_enable_i,
    input wire logic ladder_range_bit_i,
    input wire logic [4:0] ladder_numerator_i,
    input wire logic [7:0] pos_level_i,
    input wire logic [7:0] neg_level_i,
    output logic compare_result_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Ninety-sixths keep both the 32 and the 24 ladder exact in integers.
    int vref;
    int vpos;
    int vneg;
    always_comb begin
        vref = !ladder_enable_i ? 0 : (ladder_range_bit_i ? 4 : 3) * int'(ladder_numerator_i);
        vpos = pos_src_internal_i ? vref : (pos_src_pin_i ? int'(pos_level_i) : 0);
        vneg = neg_src_pin_i ? int'(neg_level_i) : 0;
        compare_result_o = vpos > vneg;
    end
endmodule : ccu_analog_model

// ### tb/comparator_control_unit_tb_top.sv
// Self-checking bench for ccu_top with the analog core model on its far side.
// Assumes the checker file is compiled alongside for its bind.
module comparator_control_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic clk_gate_en_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, res, psp, psi, nsp, len, lrg, rpin, irq, trig, er;
    logic [4:0] lnum;
    logic [7:0] neg_lv = 8'h3c;
    logic [7:0] lfsr = 8'h1d;
    int fail_count = 0, tests_run = 0, trig_cnt = 0, m_raw = 0;
    always #4 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) if (trig === 1'b1) trig_cnt++;
    ccu_top dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .clk_gate_en_i(clk_gate_en_i),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .compare_result_i(res),
        .pos_src_pin_o(psp), .pos_src_internal_o(psi), .neg_src_pin_o(nsp),
        .ladder_enable_o(len), .ladder_range_bit_o(lrg), .ladder_numerator_o(lnum),
        .result_output_pin_o(rpin), .irq_o(irq), .adc_trigger_o(trig));
    ccu_analog_model partner (.pos_src_pin_i(psp), .pos_src_internal_i(psi),
        .neg_src_pin_i(nsp), .ladder_enable_i(len), .ladder_range_bit_i(lrg),
        .ladder_numerator_i(lnum), .pos_level_i(8'h30), .neg_level_i(neg_lv),
        .compare_result_o(res));
    // ======================================================================
    // Tasks
    // ======================================================================
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : tick
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        tick(1);
        penable <= 1'b1;
        do begin
            tick(1);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        tick(1);
    endtask : apb
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(nm, rd, exp);
    endtask : rdc
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    initial begin
        #400000;
        fail_count++;
        stop_test();
    end
    // ======================================================================
    // Main sequence
    // ======================================================================
    initial begin
        logic [11:0] map [6];
        logic [31:0] d;
        map = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h020, 12'h024};
        tick(12);
        rst_b_i <= 1'b1;
        tick(2);
        // Level sense at level zero matches the low result, so raw status sets at once.
        foreach (map[i]) rdc("reset_value", map[i], 32'(map[i] == 12'h004));
        apb(1'b0, 12'h00c, 32'h0000_0000);
        check("unmapped_err", 32'(er), 32'h0000_0001);
        clk_gate_en_i <= 1'b0;
        apb(1'b1, 12'h010, 32'h0000_030c);
        check("gate_err", 32'(er), 32'h0000_0001);
        clk_gate_en_i <= 1'b1;
        rdc("gate_write_ignored", 12'h010, 32'h0000_0000);
        $display("test map done");
        for (int i = 0; i < 9; i++) begin
            lfsr = lfsr_next(lfsr);
            d = (i == 8) ? 32'h0000_030c : {22'h00_0000, lfsr[5:4], 4'h0, lfsr[3:0]};
            apb(1'b1, 12'h010, d);
            tick(2);
            check("ladder_num", 32'(lnum), !d[9] ? 0 : d[3:0] + (d[8] ? 0 : 8));
            check("ladder_bits", 32'({len, lrg}), 32'(d[9:8]));
            rdc("ref_readback", 12'h010, d);
        end
        $display("test ladder done");
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, 12'h024, 32'(c) << 9);
            tick(2);
            check("src_route", 32'({psp, psi, nsp}), {c < 2, c == 2, 1'b1});
        end
        $display("test source done");
        neg_lv <= 8'h1e;
        apb(1'b1, 12'h024, 32'h0000_040c);
        tick(6);
        check("internal_sel", 32'(psi), 32'h0000_0001);
        rdc("status_high", 12'h020, 32'h0000_0002);
        check("pin_plain", 32'(rpin), 32'h0000_0001);
        apb(1'b1, 12'h024, 32'h0000_040e);
        tick(2);
        check("pin_invert", 32'(rpin), 32'h0000_0000);
        neg_lv <= 8'h3c;
        tick(6);
        rdc("status_low", 12'h020, 32'h0000_0000);
        $display("test result done");
        apb(1'b1, 12'h024, 32'h0000_0c28);
        tick(4);
        apb(1'b1, 12'h000, 32'h0000_0001);
        apb(1'b1, 12'h008, 32'h0000_0001);
        rdc("inten_rw", 12'h008, 32'h0000_0001);
        trig_cnt = 0;
        neg_lv <= 8'h1e;
        m_raw = 1;
        tick(6);
        check("irq_rise", 32'(irq), 32'(m_raw));
        check("no_trig_rise", 32'(trig_cnt), 32'h0000_0000);
        rdc("mis_set", 12'h000, 32'(m_raw));
        apb(1'b1, 12'h008, 32'h0000_0000);
        check("irq_masked", 32'(irq), 32'h0000_0000);
        rdc("mis_masked", 12'h000, 32'h0000_0000);
        rdc("ris_kept", 12'h004, 32'(m_raw));
        apb(1'b1, 12'h004, 32'h0000_0000);
        rdc("ris_read_only", 12'h004, 32'(m_raw));
        apb(1'b1, 12'h008, 32'h0000_0001);
        check("irq_unmasked", 32'(irq), 32'h0000_0001);
        apb(1'b1, 12'h000, 32'h0000_0001);
        m_raw = 0;
        rdc("ris_cleared", 12'h004, 32'(m_raw));
        neg_lv <= 8'h3c;
        tick(6);
        check("trig_fall", 32'(trig_cnt), 32'h0000_0001);
        check("irq_quiet_fall", 32'(irq), 32'h0000_0000);
        $display("test interrupt done");
        stop_test();
    end
endmodule : comparator_control_unit_tb_top
